//--- src/plane_helper_cfg.svh
// Offsets, field positions and counts for the plane helper datapath.
`ifndef PLANE_HELPER_CFG_SVH
`define PLANE_HELPER_CFG_SVH
// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define PH_CTRL_ADDR 4'h0
`define PH_FUNC_ADDR 4'h4
`define PH_PIXEL_ADDR 4'h8
`define PH_STATUS_ADDR 4'hC
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define PH_CTRL_SHIFT_LSB 0
`define PH_CTRL_SHIFT_MSB 3
`define PH_CTRL_SWAP_BIT 4
`define PH_CTRL_LM_LSB 8
`define PH_CTRL_LM_MSB 11
`define PH_CTRL_RM_LSB 12
`define PH_CTRL_RM_MSB 15
`define PH_CTRL_RESET 16'h0000
`define PH_FUNC_RESET 4'h0
`define PH_WORD_W 16
`define PH_FIFO_DEPTH 16
`endif

//--- src/plane_helper_pkg.sv
// Types shared by the plane helper datapath.
package plane_helper_pkg;
  typedef struct packed {
    logic [3:0] pixel_addr;
    logic line_mode;
    logic left_mask_en;
    logic right_mask_en;
  } mode_inputs_t;
  typedef struct packed {
    logic data_latch_enable;
    logic pixel_latch_enable;
    logic fifo_write_strobe;
    logic fifo_read_strobe;
    logic data_output_enable;
    logic pixel_output_enable;
  } strobes_t;
  typedef enum logic [1:0] {
    WB_IDLE = 2'b01,
    WB_ACK = 2'b10
  } wb_state_t;
endpackage

//--- src/plane_helper_unit.sv
// Per-bitplane shift, FIFO and logic-combine datapath with a Wishbone register port.
`timescale 1ns/100ps
`include "plane_helper_cfg.svh"
// Behaviour
// - Shifter bit k from upper/lower word
// - Pixel port: input latch, output latch
// - Pixel output is unmodified addressed destination bit
// - Second source word pushes first to shifter
// - Swap mux feeds shifter, one aligned word
// - Aligned word written to FIFO on write strobe rising edge
// - FIFO word combined, masked, driven out
// - Line mode replicates pixel bit sixteen times
// - Line mode masks all but addressed bit
// - Routing follows registers and control inputs
// - Reset returns FIFO pointers to zero
// - One unit per plane, pixel writes parallel
// - Swap bit picks upper and lower positions
// - Logic result is OR of four minterms
// - Mode low block transfer, high line
// - Sixteen-word FIFO with ring pointers
module plane_helper_unit #(
  parameter int WORD_W = `PH_WORD_W,
  parameter int FIFO_DEPTH = `PH_FIFO_DEPTH
) (
  // Clock, enable and reset
  input wire logic ref_clk,
  input wire logic clk_en,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Data port pins
  input wire logic [WORD_W-1:0] data_in,
  output logic [WORD_W-1:0] data_out,
  output logic data_oe_n,
  // Pixel pin
  input wire logic pixel_in,
  output logic pixel_out,
  output logic pixel_oe_n,
  // Control pins
  input wire plane_helper_pkg::mode_inputs_t mode_pins,
  input wire plane_helper_pkg::strobes_t strobe_pins
);
  import plane_helper_pkg::*;

  localparam int PTR_W = $clog2(FIFO_DEPTH);

  // ----------------------------------------
  // Reset and pin synchronisers
  // ----------------------------------------
  logic rst_meta_reg, rst_sync_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Data, pixel and control pins are asynchronous to ref_clk, so they pass two stages; the Wishbone inputs are used directly.
  localparam int PIN_W = WORD_W + 1 + $bits(mode_inputs_t) + $bits(strobes_t);
  logic [PIN_W-1:0] pin_meta_reg, pin_sync_reg;
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else if (clk_en) begin
      pin_meta_reg <= {data_in, pixel_in, mode_pins, strobe_pins};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  logic [WORD_W-1:0] d_in;
  logic px_in;
  mode_inputs_t md;
  strobes_t st;
  assign {d_in, px_in, md, st} = pin_sync_reg;

  // Latch and FIFO strobes act on their rising edge, so a held level loads once; the output enables act on level.
  strobes_t st_prev_reg;
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) st_prev_reg <= '0;
    else if (clk_en) st_prev_reg <= st;
  end
  strobes_t st_rise;
  assign st_rise = st & ~st_prev_reg;

  // ----------------------------------------
  // Wishbone registers
  // ----------------------------------------
  logic [15:0] ctrl_reg;
  logic [3:0] func_code_reg;
  logic [WORD_W-1:0] source_word_latch, shifter_first_word_latch, dest_latch;
  logic pixel_in_latch, pixel_out_latch;
  logic [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg;
  wb_state_t wb_state_reg;

  logic wb_req;
  assign wb_req = wb_cyc_i && wb_stb_i && wb_state_reg == WB_IDLE;

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      wb_state_reg <= WB_IDLE;
    end else if (clk_en) begin
      unique case (wb_state_reg)
        WB_IDLE: begin
          if (wb_req) wb_state_reg <= WB_ACK;
        end
        WB_ACK: begin
          wb_state_reg <= WB_IDLE;
        end
      endcase
    end
  end
  assign wb_ack_o = wb_state_reg == WB_ACK;

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ctrl_reg <= `PH_CTRL_RESET;
    end else if (clk_en && wb_req && wb_we_i && wb_adr_i == `PH_CTRL_ADDR) begin
      if (wb_sel_i[0]) ctrl_reg[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) ctrl_reg[15:8] <= wb_dat_i[15:8];
    end
  end

  // Only byte lane 0 carries the four function bits.
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      func_code_reg <= `PH_FUNC_RESET;
    end else if (clk_en && wb_req && wb_we_i && wb_adr_i == `PH_FUNC_ADDR && wb_sel_i[0]) begin
      func_code_reg <= wb_dat_i[3:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      wb_dat_o <= 32'h00000000;
    end else if (clk_en && wb_req) begin
      unique case (wb_adr_i)
        `PH_CTRL_ADDR: wb_dat_o <= {16'h0000, ctrl_reg};
        `PH_FUNC_ADDR: wb_dat_o <= {28'h0000000, func_code_reg};
        `PH_PIXEL_ADDR: wb_dat_o <= {30'h0, pixel_out_latch, pixel_in_latch};
        `PH_STATUS_ADDR: wb_dat_o <= {24'h000000, 4'(rd_ptr_reg), 4'(wr_ptr_reg)};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  logic [3:0] shift_amt, left_mask_sel, right_mask_sel;
  logic swap_sel;
  assign shift_amt = ctrl_reg[`PH_CTRL_SHIFT_MSB:`PH_CTRL_SHIFT_LSB];
  assign swap_sel = ctrl_reg[`PH_CTRL_SWAP_BIT];
  assign left_mask_sel = ctrl_reg[`PH_CTRL_LM_MSB:`PH_CTRL_LM_LSB];
  assign right_mask_sel = ctrl_reg[`PH_CTRL_RM_MSB:`PH_CTRL_RM_LSB];

  // ----------------------------------------
  // Source and destination latches
  // ----------------------------------------
  // The data latch strobe loads source in block mode, destination in line mode or while the FIFO read strobe is high.
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      source_word_latch <= '0;
    end else if (clk_en && st_rise.data_latch_enable && !md.line_mode) begin
      source_word_latch <= d_in;
    end
  end

  // The first word moves on as the second arrives, so both reach the shifter together.
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      shifter_first_word_latch <= '0;
    end else if (clk_en && st_rise.data_latch_enable && !md.line_mode) begin
      shifter_first_word_latch <= source_word_latch;
    end
  end

  // Destination capture rides on the same strobe while the FIFO is read.
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) dest_latch <= '0;
    else if (clk_en && st_rise.data_latch_enable && (md.line_mode || st.fifo_read_strobe))
      dest_latch <= d_in;
  end

  // ----------------------------------------
  // Swap mux and barrel shifter
  // ----------------------------------------
  function automatic logic [WORD_W-1:0] barrel(input logic [WORD_W-1:0] a,
                                               input logic [WORD_W-1:0] b,
                                               input logic [3:0] i);
    logic [2*WORD_W-1:0] cat;
    cat = {b, a};
    barrel = cat[i +: WORD_W];
  endfunction

  logic [WORD_W-1:0] upper_word, lower_word, aligned_word;
  assign upper_word = swap_sel ? source_word_latch : shifter_first_word_latch;
  assign lower_word = swap_sel ? shifter_first_word_latch : source_word_latch;
  assign aligned_word = barrel(upper_word, lower_word, shift_amt);

  // ----------------------------------------
  // FIFO
  // ----------------------------------------
  // Pointers wrap silently; the controller keeps counts in range.
  logic [WORD_W-1:0] fifo_mem [FIFO_DEPTH];
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      wr_ptr_reg <= '0;
    end else if (clk_en && st_rise.fifo_write_strobe) begin
      wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rd_ptr_reg <= '0;
    end else if (clk_en && st_rise.fifo_read_strobe) begin
      rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (clk_en && st_rise.fifo_write_strobe) fifo_mem[wr_ptr_reg] <= aligned_word;
  end

  // ----------------------------------------
  // Logic combine unit and masks
  // ----------------------------------------
  function automatic logic [WORD_W-1:0] combine(input logic [WORD_W-1:0] s,
                                                input logic [WORD_W-1:0] d,
                                                input logic [3:0] f);
    combine = ({WORD_W{f[3]}} & ~s & ~d) | ({WORD_W{f[2]}} & ~s & d)
            | ({WORD_W{f[1]}} & s & ~d) | ({WORD_W{f[0]}} & s & d);
  endfunction

  function automatic logic [WORD_W-1:0] bit_sel(input logic [3:0] n);
    bit_sel = WORD_W'(1) << n;
  endfunction

  logic [WORD_W-1:0] left_mask, right_mask, blit_mask, line_mask, fifo_word, src_word, result;
  // Per-bit compare keeps the widest right mask open, where a shift would wrap.
  for (genvar b = 0; b < WORD_W; b++) begin : g_mask
    assign left_mask[b] = 32'(left_mask_sel) <= WORD_W - 1 - b;
    assign right_mask[b] = 32'(right_mask_sel) >= WORD_W - 1 - b;
  end
  assign blit_mask = (md.left_mask_en ? left_mask : {WORD_W{1'b1}})
                   & (md.right_mask_en ? right_mask : {WORD_W{1'b1}});
  assign line_mask = bit_sel(4'(WORD_W - 1 - 32'(md.pixel_addr)));
  assign fifo_word = fifo_mem[rd_ptr_reg];
  assign src_word = md.line_mode ? {WORD_W{pixel_in_latch}} : fifo_word;
  always_comb begin
    logic [WORD_W-1:0] msk;
    msk = md.line_mode ? line_mask : blit_mask;
    result = (combine(src_word, dest_latch, func_code_reg) & msk) | (dest_latch & ~msk);
  end

  // ----------------------------------------
  // Output registers and pixel port
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      pixel_in_latch <= 1'b0;
    end else if (clk_en && st_rise.pixel_latch_enable) begin
      pixel_in_latch <= px_in;
    end
  end

  // The output pixel is raw destination data, never the combined result.
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      pixel_out_latch <= 1'b0;
    end else if (clk_en) begin
      pixel_out_latch <= dest_latch[WORD_W-1-32'(md.pixel_addr)];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      data_out <= '0;
    end else if (clk_en) begin
      data_out <= result;
    end
  end

  // Enables are registered so the pins never glitch between strobes.
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      data_oe_n <= 1'b1;
      pixel_oe_n <= 1'b1;
    end else if (clk_en) begin
      data_oe_n <= !st.data_output_enable;
      pixel_oe_n <= !st.pixel_output_enable;
    end
  end
  assign pixel_out = pixel_out_latch;
endmodule

//--- dv/plane_helper_unit_asserts.sv
// Port-level checker for the plane helper datapath.
`timescale 1ns/100ps
module plane_helper_unit_asserts #(
  parameter int WORD_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic clk_en,
  input wire logic rst_n,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins
  input wire logic [WORD_W-1:0] data_in,
  input wire logic [WORD_W-1:0] data_out,
  input wire logic data_oe_n,
  input wire logic pixel_in,
  input wire logic pixel_out,
  input wire logic pixel_oe_n,
  input wire plane_helper_pkg::mode_inputs_t mode_pins,
  input wire plane_helper_pkg::strobes_t strobe_pins
);
  import plane_helper_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_ack_next: assert property (clk_en && wb_cyc_i && $rose(wb_stb_i) |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_rdata_hold: assert property (!wb_cyc_i |=> $stable(wb_dat_o))
    else $error("read data moved while idle");
  chk_doe_on: assert property (strobe_pins.data_output_enable [*5] |-> !data_oe_n)
    else $error("data pins not driven");
  chk_doe_off: assert property (!strobe_pins.data_output_enable [*5] |-> data_oe_n)
    else $error("data pins driven while disabled");
  chk_poe_on: assert property (strobe_pins.pixel_output_enable [*5] |-> !pixel_oe_n)
    else $error("pixel pin not driven");
  chk_reset_idle: assert property ($rose(rst_n) |-> data_oe_n && pixel_oe_n && data_out == '0)
    else $error("outputs not idle at reset release");
  chk_quiet_hold: assert property ((strobe_pins == '0 && !wb_cyc_i && $stable(mode_pins)) [*6]
    |-> $stable(data_out) && $stable(pixel_out))
    else $error("outputs moved with no cause");
  cover property (wb_ack_o && wb_we_i);
  cover property ($rose(strobe_pins.fifo_write_strobe));
  cover property (mode_pins.line_mode && $rose(strobe_pins.data_latch_enable));
endmodule
bind plane_helper_unit plane_helper_unit_asserts #(.WORD_W(WORD_W)) u_chk (
  .ref_clk(ref_clk), .clk_en(clk_en), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .data_in(data_in), .data_out(data_out),
  .data_oe_n(data_oe_n), .pixel_in(pixel_in), .pixel_out(pixel_out), .pixel_oe_n(pixel_oe_n),
  .mode_pins(mode_pins), .strobe_pins(strobe_pins));

//--- dv/plane_ctrl_model.sv
// Behavioural model of the controller that strobes the datapath pins.
`timescale 1ns/100ps
module plane_ctrl_model (
  // Clock
  input wire logic ref_clk,
  // Pins towards the datapath
  output logic [15:0] data_in,
  output logic pixel_in,
  output plane_helper_pkg::strobes_t strobe_pins
);
  import plane_helper_pkg::*;
  initial begin
    data_in = 16'h0000;
    pixel_in = 1'b0;
    strobe_pins = '0;
  end
  // Data is held past the input synchroniser, then inverted so stale values never help.
  task automatic pulse(input int idx, input logic [15:0] w, input logic p);
    data_in <= w;
    pixel_in <= p;
    strobe_pins[idx] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    strobe_pins[idx] <= 1'b0;
    repeat (2) @(posedge ref_clk);
    data_in <= ~w;
    pixel_in <= ~p;
    @(posedge ref_clk);
  endtask
  task automatic level(input int idx, input logic v);
    strobe_pins[idx] <= v;
    repeat (2) @(posedge ref_clk);
  endtask
endmodule

//--- dv/plane_helper_unit_tb_top.sv
// Self-checking bench for the plane helper datapath.
`timescale 1ns/100ps
`include "plane_helper_cfg.svh"
module plane_helper_unit_tb_top;
  import plane_helper_pkg::*;
  localparam int DL = 5, PL = 4, FW = 3, FR = 2;
  logic ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pixel_in, pixel_out;
  logic data_oe_n, pixel_oe_n;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] data_in, data_out;
  mode_inputs_t mode_pins;
  strobes_t strobe_pins;
  int bad_count = 0, check_count = 0, cycles = 0;
  plane_helper_unit dut (.ref_clk(ref_clk), .clk_en(1'b1), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .pixel_in(pixel_in), .pixel_out(pixel_out),
    .pixel_oe_n(pixel_oe_n), .mode_pins(mode_pins), .strobe_pins(strobe_pins));
  plane_ctrl_model u_ctl (.ref_clk(ref_clk), .data_in(data_in), .pixel_in(pixel_in),
    .strobe_pins(strobe_pins));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Classic single cycle; waits on ack with no assumed latency.
  task automatic wb_cycle(input logic we, input logic [3:0] adr, input logic [3:0] sel,
                          input logic [31:0] wd);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= wd;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic test_regs();
    logic [3:0] a[5] = '{`PH_CTRL_ADDR, `PH_FUNC_ADDR, `PH_PIXEL_ADDR, `PH_STATUS_ADDR, 4'h2};
    foreach (a[k]) begin
      wb_cycle(1'b0, a[k], 4'hF, 32'h0);
      check(rd, 32'h0);
    end
    wb_cycle(1'b1, `PH_STATUS_ADDR, 4'hF, 32'h0000_00FF);
    wb_cycle(1'b0, `PH_STATUS_ADDR, 4'hF, 32'h0);
    check(rd, 32'h0);
    wb_cycle(1'b1, `PH_CTRL_ADDR, 4'h3, 32'h0000_F31E);
    wb_cycle(1'b0, `PH_CTRL_ADDR, 4'hF, 32'h0);
    check(rd, 32'h0000_F31E);
    $display("register test done");
  endtask
  task automatic test_block();
    logic [15:0] w1, w2, s, d, e;
    logic [31:0] t;
    logic [3:0] f;
    mode_pins <= '0;
    for (int k = 0; k < 32; k++) begin
      w1 = 16'hC35A + 16'(k) * 16'h0111;
      w2 = w1 ^ 16'h96F0;
      d = 16'h6A93 ^ 16'(k);
      f = 4'(k);
      wb_cycle(1'b1, `PH_CTRL_ADDR, 4'h3, {27'h0, k[4], f});
      wb_cycle(1'b1, `PH_FUNC_ADDR, 4'h1, {28'h0, f});
      u_ctl.pulse(DL, w1, 1'b0);
      u_ctl.pulse(DL, w2, 1'b0);
      repeat (16) u_ctl.pulse(FW, ~d, 1'b0);
      u_ctl.level(FR, 1'b1);
      u_ctl.pulse(DL, d, 1'b0);
      t = k[4] ? {w1, w2} >> f : {w2, w1} >> f;
      s = t[15:0];
      e = (f[3] ? ~s & ~d : 16'h0) | (f[2] ? ~s & d : 16'h0) | (f[1] ? s & ~d : 16'h0) |
          (f[0] ? s & d : 16'h0);
      check(32'(data_out), 32'(e));
      u_ctl.level(FR, 1'b0);
    end
    $display("block test done");
  endtask
  task automatic test_pointers();
    wb_cycle(1'b0, `PH_STATUS_ADDR, 4'hF, 32'h0);
    check(32'(rd[3:0]), 32'h0);
    u_ctl.pulse(FW, 16'h0, 1'b0);
    wb_cycle(1'b0, `PH_STATUS_ADDR, 4'hF, 32'h0);
    check(32'(rd[3:0]), 32'h1);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    wb_cycle(1'b0, `PH_STATUS_ADDR, 4'hF, 32'h0);
    check(rd, 32'h0);
    $display("pointer test done");
  endtask
  task automatic test_fifo();
    logic [15:0] v[5];
    foreach (v[j]) v[j] = 16'h5A00 | 16'(j * 37);
    wb_cycle(1'b1, `PH_CTRL_ADDR, 4'h3, 32'h0);
    wb_cycle(1'b1, `PH_FUNC_ADDR, 4'h1, 32'h3);
    mode_pins <= '0;
    foreach (v[j]) begin
      u_ctl.pulse(DL, v[j], 1'b0);
      if (j > 0) u_ctl.pulse(FW, 16'h0, 1'b0);
    end
    for (int j = 0; j < 4; j++) begin
      repeat (2) @(posedge ref_clk);
      check(32'(data_out), 32'(v[j]));
      u_ctl.level(FR, 1'b1);
      u_ctl.level(FR, 1'b0);
    end
    $display("fifo test done");
  endtask
  task automatic test_line();
    logic [15:0] d, e;
    logic p;
    wb_cycle(1'b1, `PH_FUNC_ADDR, 4'h1, 32'h3);
    for (int a = 0; a < 16; a++) begin
      d = 16'hA5C3 ^ 16'(a << 5);
      p = ~d[15-a];
      mode_pins <= {4'(a), 1'b1, 2'b00};
      u_ctl.pulse(PL, ~d, p);
      u_ctl.pulse(DL, d, ~p);
      e = d;
      e[15-a] = p;
      check(32'(data_out), 32'(e));
      check(32'(pixel_out), 32'(d[15-a]));
      wb_cycle(1'b0, `PH_PIXEL_ADDR, 4'hF, 32'h0);
      check(rd, {30'h0, d[15-a], p});
    end
    $display("line test done");
  endtask
  task automatic test_enables();
    for (int k = 0; k < 2; k++) begin
      u_ctl.level(k, 1'b1);
      repeat (4) @(posedge ref_clk);
      check(32'({data_oe_n, pixel_oe_n}), 32'(k ? 2'b01 : 2'b10));
      u_ctl.level(k, 1'b0);
      repeat (4) @(posedge ref_clk);
      check(32'({data_oe_n, pixel_oe_n}), 32'h3);
    end
    $display("enable test done");
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    mode_pins = '0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    test_regs();
    test_block();
    test_pointers();
    test_fifo();
    test_line();
    test_enables();
    wrap_up();
  end
endmodule
